// file: rtl/licr_consts.svh
// register offsets, field positions, reset values and timing in nanoseconds
`ifndef LICR_CONSTS_SVH
`define LICR_CONSTS_SVH
`define LICR_IDX_CTRL1 8'h30
`define LICR_IDX_CTRL2 8'h31
`define LICR_IDX_CMI 8'h32
`define LICR_IDX_GAIN 8'h34
`define LICR_IDX_LIVE 8'h3A
`define LICR_IDX_LATCH 8'h3B
`define LICR_RST_CTRL1 8'h00
`define LICR_RST_CTRL2 8'h00
`define LICR_RST_CMI 8'h00
`define LICR_RST_GAIN 8'h00
`define LICR_BIT_POWER 0
`define LICR_BIT_JA_DIS 1
`define LICR_BIT_JA_DEPTH 2
`define LICR_BIT_JA_PATH 3
`define LICR_BIT_EQ_LIMIT 4
`define LICR_LSB_BUILDOUT 5
`define LICR_BIT_CUSTOM 0
`define LICR_BIT_SC_DIS 1
`define LICR_BIT_CMI_INV 6
`define LICR_BIT_CMI_EN 7
`define LICR_LSB_GAIN 0
`define LICR_BIT_AUTO 6
`define LICR_BIT_LIMIT 2
`define LICR_MASK_CTRL2 8'h03
`define LICR_MASK_CMI 8'hC0
`define LICR_MASK_GAIN 8'h7F
`define LICR_T1_LAST_RANGE 3'h4
`define LICR_SQUARE_NS 244
`define LICR_CMI_BIT_NS 488
`define LICR_CLOCK_NS 10
`endif

// file: rtl/licr_pkg.sv
// types shared by the line interface control block
package licr_pkg;
	typedef enum logic [1:0] {
		LICR_DRV_PULSE,
		LICR_DRV_SQUARE,
		LICR_DRV_OPEN_DRAIN,
		LICR_DRV_CMI
	} licr_drive_e;
	typedef struct packed {
		logic jitterAttenEnable;
		logic jitterDepth32;
		logic jitterInTransmit;
		logic equalizerLimited;
		logic [2:0] buildout;
		logic buildoutReserved;
		logic [2:0] cableRange;
		logic autoGain;
		logic [5:0] fixedGain;
		logic limiterEnable;
		logic cmiEnable;
		logic cmiInvert;
		logic lineCodingActive;
		logic transmitPowered;
	} licr_fe_cfg_s;
	typedef struct packed {
		logic pos;
		logic neg;
	} licr_line_s;
endpackage

// file: rtl/licr_regs.sv
// line interface control registers with apb slave and line driver control
`timescale 1ns/1ps
`include "licr_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - with cmi enabled, positive transmit line carries cmi coded data.
// - with cmi enabled, positive receive line decoded as cmi, clock recovered.
// - hdb3 or b8zs coding stays usable while cmi is enabled.
// - power bit 0 tri-states both transmit outputs; 1 runs normally.
// - control one bit 1 set disables jitter attenuator, clear enables.
// - control one bit 2 picks buffer depth: 0 is 128, 1 is 32.
// - control one bit 3 places attenuator receive side at 0, transmit at 1.
// - control one bit 4 limits receive equalizer sensitivity.
// - t1 build-out codes 0 to 4 pick cable range, 5 to 7 reserved.
// - gain field bits 0 to 5 set transmit gain without auto gain.
// - gain bit 6 clear uses auto gain; set uses the gain field.
// - custom driver with build-out zero sends a square wave.
// - custom driver with nonzero build-out makes outputs open drain.
// - control two bit 1 clear enables e1 current limiter, set disables.
// - limiter activity flagged live and latched in status bit 2.
module licr_regs #(
	parameter int SQUARE_HALF_CYCLES =
		(`LICR_SQUARE_NS + `LICR_CLOCK_NS - 1) / `LICR_CLOCK_NS,
	parameter int CMI_BIT_CYCLES = `LICR_CMI_BIT_NS / `LICR_CLOCK_NS
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic networkIsE1,
	input wire licr_pkg::licr_line_s codedPulse,
	input wire logic cmiTxData,
	input wire logic shortDetect,
	input wire logic receive_line_pos,
	output licr_pkg::licr_fe_cfg_s frontEndCfg,
	output logic transmit_line_pos_o,
	output logic transmit_line_pos_oe,
	output logic transmit_line_neg_o,
	output logic transmit_line_neg_oe,
	output logic cmiRxBit,
	output logic cmiRxStrobe,
	output logic current_limit_flag
);
	import licr_pkg::*;

	localparam int PW = 8;
	localparam logic [PW-1:0] CMI_LAST = PW'(CMI_BIT_CYCLES - 1);
	localparam logic [PW-1:0] CMI_QTR = PW'(CMI_BIT_CYCLES / 4);
	localparam logic [PW-1:0] CMI_3QTR = PW'((3 * CMI_BIT_CYCLES) / 4);
	localparam logic [PW-1:0] SQ_LAST = PW'(SQUARE_HALF_CYCLES - 1);

	logic [7:0] lineCtrlOne;
	logic [7:0] lineCtrlTwo;
	logic [7:0] cmiCtrl;
	logic [7:0] gainCtrl;
	logic limitLatched;
	logic accessPhase;
	logic writeHit;
	logic readHit;
	logic [7:0] regIndex;
	logic [7:0] next_readData;
	logic next_mapped;
	logic shortSync1;
	logic shortSync2;
	logic rxSync1;
	logic rxSync2;
	logic rxLast;
	logic [PW-1:0] cmiPhase;
	logic cmiFirstHalf;
	logic [PW-1:0] squareCount;
	logic squareLevel;
	logic [2:0] buildout;
	licr_drive_e driveMode;
	licr_fe_cfg_s next_cfg;

	function automatic logic [7:0] mergeByte(input logic [7:0] old,
			input logic [7:0] data, input logic lane, input logic [7:0] mask);
		mergeByte = lane ? (data & mask) : old;
	endfunction

////////////////////////////////////////////////////////////////////////////////
// apb slave

	assign accessPhase = psel && penable && !pready;
	assign regIndex = paddr[9:2];
	assign writeHit = psel && penable && pready && pwrite && !pslverr;
	assign readHit = accessPhase && !pwrite;

	always_comb begin
		next_readData = 8'h00;
		next_mapped = 1'b1;
		unique case (regIndex)
			`LICR_IDX_CTRL1: next_readData = lineCtrlOne;
			`LICR_IDX_CTRL2: next_readData = lineCtrlTwo;
			`LICR_IDX_CMI: next_readData = cmiCtrl;
			`LICR_IDX_GAIN: next_readData = gainCtrl;
			`LICR_IDX_LIVE: next_readData[`LICR_BIT_LIMIT] = current_limit_flag;
			`LICR_IDX_LATCH: next_readData[`LICR_BIT_LIMIT] = limitLatched;
			default: next_mapped = 1'b0;
		endcase
		if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
			next_mapped = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (accessPhase) begin
			pready <= 1'b1;
			pslverr <= !next_mapped;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
		end else if (readHit) begin
			prdata <= next_mapped ? {24'h000000, next_readData} : 32'h00000000;
		end else if (!pready) begin
			prdata <= 32'h00000000;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// control registers

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lineCtrlOne <= `LICR_RST_CTRL1;
		end else if (writeHit && regIndex == `LICR_IDX_CTRL1) begin
			lineCtrlOne <= mergeByte(lineCtrlOne, pwdata[7:0], pstrb[0], 8'hFF);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lineCtrlTwo <= `LICR_RST_CTRL2;
		end else if (writeHit && regIndex == `LICR_IDX_CTRL2) begin
			lineCtrlTwo <= mergeByte(lineCtrlTwo, pwdata[7:0], pstrb[0],
				`LICR_MASK_CTRL2);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmiCtrl <= `LICR_RST_CMI;
		end else if (writeHit && regIndex == `LICR_IDX_CMI) begin
			cmiCtrl <= mergeByte(cmiCtrl, pwdata[7:0], pstrb[0],
				`LICR_MASK_CMI);
		end
	end

	// bit 7 kept at zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			gainCtrl <= `LICR_RST_GAIN;
		end else if (writeHit && regIndex == `LICR_IDX_GAIN) begin
			gainCtrl <= mergeByte(gainCtrl, pwdata[7:0], pstrb[0],
				`LICR_MASK_GAIN);
		end
	end

////////////////////////////////////////////////////////////////////////////////
// front end configuration

	assign buildout = lineCtrlOne[`LICR_LSB_BUILDOUT +: 3];

	always_comb begin
		next_cfg = '0;
		next_cfg.transmitPowered = lineCtrlOne[`LICR_BIT_POWER];
		next_cfg.jitterAttenEnable = !lineCtrlOne[`LICR_BIT_JA_DIS];
		next_cfg.jitterDepth32 = lineCtrlOne[`LICR_BIT_JA_DEPTH];
		next_cfg.jitterInTransmit = lineCtrlOne[`LICR_BIT_JA_PATH];
		next_cfg.equalizerLimited = lineCtrlOne[`LICR_BIT_EQ_LIMIT];
		next_cfg.buildout = buildout;
		if (!networkIsE1) begin
			if (buildout > `LICR_T1_LAST_RANGE) begin
				next_cfg.buildoutReserved = 1'b1;
			end else begin
				next_cfg.cableRange = buildout;
			end
		end
		next_cfg.autoGain = !gainCtrl[`LICR_BIT_AUTO];
		if (gainCtrl[`LICR_BIT_AUTO]) begin
			next_cfg.fixedGain = gainCtrl[`LICR_LSB_GAIN +: 6];
		end
		next_cfg.limiterEnable = networkIsE1 &&
			!lineCtrlTwo[`LICR_BIT_SC_DIS];
		next_cfg.cmiEnable = cmiCtrl[`LICR_BIT_CMI_EN];
		next_cfg.cmiInvert = cmiCtrl[`LICR_BIT_CMI_INV];
		// line coder left running whatever the cmi setting
		next_cfg.lineCodingActive = 1'b1;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			frontEndCfg <= '0;
		end else begin
			frontEndCfg <= next_cfg;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// transmit line driver

	always_comb begin
		if (cmiCtrl[`LICR_BIT_CMI_EN]) begin
			driveMode = LICR_DRV_CMI;
		end else if (lineCtrlTwo[`LICR_BIT_CUSTOM] && buildout == 3'h0) begin
			driveMode = LICR_DRV_SQUARE;
		end else if (lineCtrlTwo[`LICR_BIT_CUSTOM]) begin
			driveMode = LICR_DRV_OPEN_DRAIN;
		end else begin
			driveMode = LICR_DRV_PULSE;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			squareCount <= '0;
			squareLevel <= 1'b0;
		end else if (squareCount == SQ_LAST) begin
			squareCount <= '0;
			squareLevel <= !squareLevel;
		end else begin
			squareCount <= squareCount + PW'(1);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			transmit_line_pos_o <= 1'b0;
			transmit_line_neg_o <= 1'b0;
			transmit_line_pos_oe <= 1'b1;
			transmit_line_neg_oe <= 1'b1;
		end else if (!lineCtrlOne[`LICR_BIT_POWER]) begin
			transmit_line_pos_o <= 1'b0;
			transmit_line_neg_o <= 1'b0;
			transmit_line_pos_oe <= 1'b1;
			transmit_line_neg_oe <= 1'b1;
		end else begin
			unique case (driveMode)
				LICR_DRV_CMI: begin
					transmit_line_pos_o <= cmiTxData ^
						cmiCtrl[`LICR_BIT_CMI_INV];
					transmit_line_pos_oe <= 1'b0;
					transmit_line_neg_o <= 1'b0;
					transmit_line_neg_oe <= 1'b0;
				end
				LICR_DRV_SQUARE: begin
					transmit_line_pos_o <= squareLevel;
					transmit_line_neg_o <= !squareLevel;
					transmit_line_pos_oe <= 1'b0;
					transmit_line_neg_oe <= 1'b0;
				end
				LICR_DRV_OPEN_DRAIN: begin
					// pull low only, release otherwise
					transmit_line_pos_o <= 1'b0;
					transmit_line_neg_o <= 1'b0;
					transmit_line_pos_oe <= !codedPulse.pos;
					transmit_line_neg_oe <= !codedPulse.neg;
				end
				LICR_DRV_PULSE: begin
					transmit_line_pos_o <= codedPulse.pos;
					transmit_line_neg_o <= codedPulse.neg;
					transmit_line_pos_oe <= 1'b0;
					transmit_line_neg_oe <= 1'b0;
				end
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// short circuit flag

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shortSync1 <= 1'b0;
			shortSync2 <= 1'b0;
		end else begin
			shortSync1 <= shortDetect;
			shortSync2 <= shortSync1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			current_limit_flag <= 1'b0;
		end else begin
			current_limit_flag <= shortSync2;
		end
	end

	// set wins over write-one clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			limitLatched <= 1'b0;
		end else if (current_limit_flag) begin
			limitLatched <= 1'b1;
		end else if (writeHit && regIndex == `LICR_IDX_LATCH && pstrb[0] &&
				pwdata[`LICR_BIT_LIMIT]) begin
			limitLatched <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// cmi receive decoder

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rxSync1 <= 1'b0;
			rxSync2 <= 1'b0;
			rxLast <= 1'b0;
		end else begin
			rxSync1 <= receive_line_pos;
			rxSync2 <= rxSync1;
			rxLast <= rxSync2;
		end
	end

	// edges late in the bit realign the phase to a bit boundary
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmiPhase <= '0;
		end else if (rxSync2 != rxLast && cmiPhase > CMI_3QTR) begin
			cmiPhase <= '0;
		end else if (cmiPhase == CMI_LAST) begin
			cmiPhase <= '0;
		end else begin
			cmiPhase <= cmiPhase + PW'(1);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmiFirstHalf <= 1'b0;
		end else if (cmiPhase == CMI_QTR) begin
			cmiFirstHalf <= rxSync2;
		end
	end

	// equal halves mean a one, a mid-bit change a zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmiRxBit <= 1'b0;
			cmiRxStrobe <= 1'b0;
		end else if (cmiCtrl[`LICR_BIT_CMI_EN] && cmiPhase == CMI_3QTR) begin
			cmiRxBit <= (cmiFirstHalf == rxSync2);
			cmiRxStrobe <= 1'b1;
		end else begin
			cmiRxStrobe <= 1'b0;
		end
	end
endmodule

// file: testbench/licr_regs_chk.sv
// port assertions for the line interface control registers
`timescale 1ns/1ps
module licr_regs_chk
	import licr_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic networkIsE1,
	input wire logic cmiTxData,
	input wire logic shortDetect,
	input wire licr_pkg::licr_fe_cfg_s frontEndCfg,
	input wire logic transmit_line_pos_o,
	input wire logic transmit_line_pos_oe,
	input wire logic transmit_line_neg_oe,
	input wire logic current_limit_flag
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	licr_fe_cfg_s c;
	logic [7:0] wrData;
	logic wrDone;
	assign c = frontEndCfg;
	assign wrDone = psel && penable && pready && pwrite && pstrb[0];
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			wrData <= 8'h00;
		else if (wrDone)
			wrData <= pwdata[7:0];
	end
	sequence oneWait;
		!pready ##1 pready;
	endsequence
	sequence wrAt(logic [11:0] a);
		wrDone && !pslverr && paddr == a;
	endsequence
	AST_APB_WAIT: assert property (psel && !penable |=> oneWait)
		else $error("apb answer not after one wait state");
	AST_REFUSE: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access not refused");
	AST_CTRL1_MAP: assert property (
		wrAt(12'h0C0) |-> ##2 {c.jitterAttenEnable, c.jitterDepth32,
		c.jitterInTransmit, c.equalizerLimited, c.buildout} ==
		{!wrData[1], wrData[2], wrData[3], wrData[4], wrData[7:5]})
		else $error("control one fields wrong");
	AST_GAIN_MAP: assert property (
		wrAt(12'h0D0) |-> ##2 c.autoGain == !wrData[6] &&
		c.fixedGain == (wrData[6] ? wrData[5:0] : 6'h00))
		else $error("gain fields wrong");
	AST_LIMITER: assert property (
		wrAt(12'h0C4) |-> ##2 c.limiterEnable == (networkIsE1 && !wrData[1]))
		else $error("limiter enable wrong");
	AST_LIMIT_FLAG: assert property (
		current_limit_flag == $past(shortDetect, 3))
		else $error("live limit flag wrong");
	AST_POWER_OFF: assert property (
		(!c.transmitPowered)[*2] |-> transmit_line_pos_oe && transmit_line_neg_oe)
		else $error("transmit lines driven while powered down");
	AST_CMI_TX: assert property (
		(c.transmitPowered && c.cmiEnable)[*2] ##0 $stable(c.cmiInvert) |->
		!transmit_line_pos_oe &&
		transmit_line_pos_o == $past(cmiTxData ^ c.cmiInvert))
		else $error("cmi transmit level wrong");
	AST_CODING: assert property (c.cmiEnable |-> c.lineCodingActive)
		else $error("line coding dropped with cmi");
	AST_RESERVED: assert property (
		$stable(networkIsE1) && $stable(c.buildout) |->
		c.buildoutReserved == (!networkIsE1 && c.buildout > 3'h4))
		else $error("reserved build-out flag wrong");
endmodule
bind licr_regs licr_regs_chk u_chk (.clock(clock), .resetn(resetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
	.networkIsE1(networkIsE1), .cmiTxData(cmiTxData),
	.shortDetect(shortDetect), .frontEndCfg(frontEndCfg),
	.transmit_line_pos_o(transmit_line_pos_o),
	.transmit_line_pos_oe(transmit_line_pos_oe),
	.transmit_line_neg_oe(transmit_line_neg_oe),
	.current_limit_flag(current_limit_flag));

// file: testbench/licr_fe_model.sv
// front end model: short detector and cmi receive stream
`timescale 1ns/1ps
module licr_fe_model #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic shortOn,
	input wire logic sendOnes,
	output logic shortDetect,
	output logic receive_line_pos
);
	int phase;
	logic level;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			phase <= 0;
			level <= 1'b0;
		end else begin
			phase <= (phase == BIT_CYCLES - 1) ? 0 : phase + 1;
			if (phase == BIT_CYCLES - 1)
				level <= ~level;
		end
	end
	// ones hold a full period and alternate, zeros rise mid period
	assign receive_line_pos = sendOnes ? level : (phase >= BIT_CYCLES / 2);
	assign shortDetect = shortOn;
endmodule

// file: testbench/test_line_interface_control_regs.sv
// self-checking bench for the line interface control registers
`timescale 1ns/1ps
module test_line_interface_control_regs;
	import licr_pkg::*;
	localparam int SQ = 4;
	localparam int CB = 16;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, shortDetect, rxPos, cmiTxData = 1'b0;
	logic networkIsE1 = 1'b0, shortOn = 1'b0, sendOnes = 1'b1;
	licr_line_s codedPulse = 2'b10;
	licr_fe_cfg_s cfg;
	logic tpO, tpOe, tnO, tnOe, rxBit, rxStb, limFlag;
	int error_cnt = 0, samples_checked = 0, k, n1;
	always #5 clock = ~clock;
	licr_regs #(.SQUARE_HALF_CYCLES(SQ), .CMI_BIT_CYCLES(CB)) DUT (
		.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.networkIsE1(networkIsE1), .codedPulse(codedPulse),
		.cmiTxData(cmiTxData), .shortDetect(shortDetect),
		.receive_line_pos(rxPos), .frontEndCfg(cfg),
		.transmit_line_pos_o(tpO), .transmit_line_pos_oe(tpOe),
		.transmit_line_neg_o(tnO), .transmit_line_neg_oe(tnOe),
		.cmiRxBit(rxBit), .cmiRxStrobe(rxStb), .current_limit_flag(limFlag));
	licr_fe_model #(.BIT_CYCLES(CB)) frontEnd (.clock(clock),
		.resetn(resetn), .shortOn(shortOn), .sendOnes(sendOnes),
		.shortDetect(shortDetect), .receive_line_pos(rxPos));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			check(0, 1);
			conclude();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		check(er, 0);
		repeat (3) @(posedge clock);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic x);
		apb(1'b0, a, 8'h00);
		check(rd, {24'h0, e});
		check(er, x);
	endtask
	task automatic rxRun(input logic ones);
		int s, o;
		sendOnes <= ones;
		repeat (4 * CB) @(posedge clock);
		s = 0;
		o = 0;
		for (int i = 0; i < 10 * CB; i++) begin
			@(posedge clock);
			s += (rxStb === 1'b1);
			o += (rxStb === 1'b1 && rxBit === 1'b1);
		end
		check(s, 10);
		check(o, ones ? 10 : 0);
	endtask
	initial begin
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		rdc(12'h0C0, 8'h00, 0);
		rdc(12'h0C4, 8'h00, 0);
		rdc(12'h0D0, 8'h00, 0);
		check({tpOe, tnOe}, 2'b11);
		wr(12'h0C4, 8'hFF);
		rdc(12'h0C4, 8'h03, 0);
		wr(12'h0C4, 8'h00);
		rdc(12'h0CC, 8'h00, 1);
		wr(12'h0C0, 8'h16);
		check(cfg[22:19], 4'b0101);
		wr(12'h0C0, 8'h08);
		check(cfg[22:19], 4'b1010);
		pstrb <= 4'hE;
		wr(12'h0C0, 8'h55);
		pstrb <= 4'hF;
		rdc(12'h0C0, 8'h08, 0);
		rdc(12'h0C1, 8'h00, 1);
		rdc(12'h4C0, 8'h00, 1);
		$display("test registers done");
		wr(12'h0C0, 8'h01);
		check({tpO, tpOe, tnO, tnOe}, 4'b1000);
		wr(12'h0C0, 8'h21);
		wr(12'h0C4, 8'h01);
		check({tpO, tpOe, tnO, tnOe}, 4'b0001);
		wr(12'h0C0, 8'h01);
		rd[0] = tpO;
		n1 = 0;
		for (k = 0; k < 4 * SQ; k++) begin
			@(posedge clock);
			n1 += (tpO !== rd[0]);
			rd[0] = tpO;
			check(tnO ^ tpO, 1);
		end
		check(n1, 4);
		wr(12'h0C4, 8'h00);
		wr(12'h0C0, 8'h00);
		check({tpOe, tnOe}, 2'b11);
		$display("test line driver done");
		wr(12'h0C0, 8'h01);
		cmiTxData <= 1'b1;
		wr(12'h0C8, 8'h80);
		check({tpO, tpOe, cfg.lineCodingActive}, 3'b101);
		cmiTxData <= 1'b0;
		wr(12'h0C8, 8'hC0);
		check({tpO, tpOe}, 2'b10);
		rdc(12'h0C8, 8'hC0, 0);
		rxRun(1'b1);
		rxRun(1'b0);
		wr(12'h0C8, 8'h00);
		$display("test cmi done");
		wr(12'h0C0, 8'hA1);
		check({cfg.buildoutReserved, cfg.cableRange}, 4'h8);
		wr(12'h0C0, 8'h81);
		check({cfg.buildoutReserved, cfg.cableRange}, 4'h4);
		wr(12'h0D0, 8'h67);
		check({cfg.autoGain, cfg.fixedGain}, 7'h27);
		wr(12'h0D0, 8'h26);
		check({cfg.autoGain, cfg.fixedGain}, 7'h40);
		networkIsE1 <= 1'b1;
		wr(12'h0C0, 8'hA1);
		check({cfg.buildoutReserved, cfg.cableRange}, 4'h0);
		wr(12'h0C4, 8'h02);
		check(cfg.limiterEnable, 0);
		wr(12'h0C4, 8'h00);
		check(cfg.limiterEnable, 1);
		$display("test settings done");
		shortOn <= 1'b1;
		repeat (5) @(posedge clock);
		check(limFlag, 1);
		rdc(12'h0E8, 8'h04, 0);
		shortOn <= 1'b0;
		repeat (5) @(posedge clock);
		check(limFlag, 0);
		rdc(12'h0EC, 8'h04, 0);
		wr(12'h0EC, 8'h04);
		rdc(12'h0EC, 8'h00, 0);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		rdc(12'h0C0, 8'h00, 0);
		check({tpOe, tnOe}, 2'b11);
		$display("test limiter and reset done");
		conclude();
	end
endmodule
